// [poc_defines.svh]
// constants for the port overcurrent protection block
`ifndef POC_DEFINES_SVH
`define POC_DEFINES_SVH
`define POC_NPORT        4
`define POC_CLK_NS       10
`define POC_TICK_NS      1000000
`define POC_TICK_CYC     (`POC_TICK_NS / `POC_CLK_NS)
`define POC_UP_DIV_MAX   2'h3
`define POC_START_TICKS  8'h3c
`define POC_OVLD_TO0     8'h3c
`define POC_OVLD_TO1     8'h1e
`define POC_OVLD_TO2     8'h0f
`define POC_OVLD_TO3     8'h78
`define POC_HARD_TO0     8'h3c
`define POC_HARD_TO1     8'h1e
`define POC_HARD_TO2     8'h0f
`define POC_HARD_TO3     8'h0a
`define POC_A_PWR_EN     8'h00
`define POC_A_OVLD_CFG   8'h04
`define POC_A_TIMING     8'h08
`define POC_A_HIGH_PWR   8'h0c
`define POC_A_EVENT      8'h10
`define POC_A_MASK       8'h14
`define POC_A_STATUS     8'h18
`define POC_EVT_INRUSH   0
`define POC_EVT_OVLD     4
`define POC_EVT_HARD     8
`define POC_TCFG_OVLD    0
`define POC_TCFG_HARD    2
`define POC_RST_OVLD_CFG 12'h333
`define POC_RST_TIMING   4'h0
`endif

// [poc_pkg.sv]
// types shared by the port overcurrent protection block
package poc_pkg;
   typedef enum logic [1:0] {ST_OFF, ST_START, ST_ON} poc_port_st_t;
   typedef struct packed {
      logic [7:0] cnt;
   } poc_timer_st_t;
endpackage

// [poc_timer.sv]
// per-port timeout counter: down on tick while active, slow up otherwise
module poc_timer
   import poc_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       tick,
   input  wire logic       up_tick,
   input  wire logic       load,
   input  wire logic       run,
   input  wire logic [7:0] cnt_max,
   output logic            expired
);
   poc_timer_st_t q;
   poc_timer_st_t d;

   always_comb begin
      d = q;
      if (load) begin
         d.cnt = cnt_max;
      end else if (run) begin
         if (tick && q.cnt != 8'h00) begin
            d.cnt = 8'(q.cnt - 8'h01);
         end
      end else if (up_tick && q.cnt < cnt_max) begin
         d.cnt = 8'(q.cnt + 8'h01);
      end else if (q.cnt > cnt_max) begin
         d.cnt = cnt_max;
      end
   end

   assign expired = run && q.cnt == 8'h00;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // poc_timer

// [poc_top.sv]
// four-port overcurrent protection sequencer with ahb-lite registers
//
// Summary of operation
// - switching a port on starts its start-window timer.
// - while the start window runs, port current is held to inrush level.
// - still inrush-limited at window end: port off, inrush flag, optional interrupt.
// - after the start window, two current-limit tiers replace inrush limit.
// - lower tier is the per-port overload threshold from its config register.
// - overload timeout comes from the overload field of timing config.
// - overload timer expiry: port off, overload flag set, optional interrupt.
// - upper tier is a hard limit enforced at once with voltage foldback.
// - hard limit value per port follows its high-power select bit.
// - hard limit starts its timer; expiry turns port off, sets flag.
// - below overload threshold, timer counts back up slower, capped at max.
// - overload threshold is a 3-bit per-port code driven to the sense stage.
// - hard limit cleared, its timer counts back up slower, capped at max.
// - after power good, high-power bit selects doubled foldback, else single.
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`include "poc_defines.svh"
module poc_top
   import poc_pkg::*;
#(
   parameter int TICK_CYCLES = `POC_TICK_CYC
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [3:0]  inrush_limiting,
   input  wire logic [3:0]  over_threshold,
   input  wire logic [3:0]  at_hard_limit,
   input  wire logic [3:0]  power_good,
   output logic [3:0]       port_gate_en,
   output logic [3:0]       inrush_limit_en,
   output logic [3:0]       hard_limit_en,
   output logic [3:0]       hard_limit_high,
   output logic [3:0]       foldback_2x,
   output logic [11:0]      overload_threshold,
   output logic             irq
);
   typedef struct packed {
      logic [3:0]          pwr_en;
      logic [11:0]         ovld_cfg;
      logic [3:0]          tcfg;
      logic [3:0]          high_pwr;
      logic [11:0]         evt;
      logic [11:0]         mask;
      poc_port_st_t [3:0]  st;
      logic [16:0]         div;
      logic [1:0]          up_div;
      logic                tick;
      logic                up_tick;
      logic [15:0]         sync1;
      logic [15:0]         sync2;
      logic                wr_pend;
      logic [7:0]          wr_addr;
      logic [31:0]         rdata;
      logic                ready;
      logic [3:0]          gate;
      logic [3:0]          inrush_lim;
      logic [3:0]          hard_en;
      logic [3:0]          hard_hi;
      logic [3:0]          fold2x;
      logic [11:0]         thr;
      logic                irq;
   } poc_top_st_t;

   poc_top_st_t q;
   poc_top_st_t d;

   logic [3:0] st_ld;
   logic [3:0] st_exp;
   logic [3:0] ov_ld;
   logic [3:0] ov_run;
   logic [3:0] ov_exp;
   logic [3:0] hl_ld;
   logic [3:0] hl_run;
   logic [3:0] hl_exp;
   logic [3:0] inrush_s;
   logic [3:0] over_s;
   logic [3:0] hard_s;
   logic [3:0] good_s;
   logic [7:0] ov_max;
   logic [7:0] hl_max;
   logic       addr_ph;

   assign inrush_s = q.sync2[3:0];
   assign over_s   = q.sync2[7:4];
   assign hard_s   = q.sync2[11:8];
   assign good_s   = q.sync2[15:12];
   assign addr_ph  = hsel && hready && htrans[1];

   always_comb begin
      unique case (q.tcfg[`POC_TCFG_OVLD +: 2])
         2'h0: ov_max = `POC_OVLD_TO0;
         2'h1: ov_max = `POC_OVLD_TO1;
         2'h2: ov_max = `POC_OVLD_TO2;
         2'h3: ov_max = `POC_OVLD_TO3;
      endcase
      unique case (q.tcfg[`POC_TCFG_HARD +: 2])
         2'h0: hl_max = `POC_HARD_TO0;
         2'h1: hl_max = `POC_HARD_TO1;
         2'h2: hl_max = `POC_HARD_TO2;
         2'h3: hl_max = `POC_HARD_TO3;
      endcase
   end

   for (genvar i = 0; i < `POC_NPORT; i++) begin : g_tmr
      poc_timer u_start (
         .hclk    (hclk),
         .hresetn (hresetn),
         .tick    (q.tick),
         .up_tick (1'b0),
         .load    (st_ld[i]),
         .run     (q.st[i] == ST_START),
         .cnt_max (`POC_START_TICKS),
         .expired (st_exp[i])
      );
      poc_timer u_ovld (
         .hclk    (hclk),
         .hresetn (hresetn),
         .tick    (q.tick),
         .up_tick (q.up_tick),
         .load    (ov_ld[i]),
         .run     (ov_run[i]),
         .cnt_max (ov_max),
         .expired (ov_exp[i])
      );
      poc_timer u_hard (
         .hclk    (hclk),
         .hresetn (hresetn),
         .tick    (q.tick),
         .up_tick (q.up_tick),
         .load    (hl_ld[i]),
         .run     (hl_run[i]),
         .cnt_max (hl_max),
         .expired (hl_exp[i])
      );
      // overload runs down only while over threshold
      assign ov_run[i] = q.st[i] == ST_ON && over_s[i];
      // hard timer runs down only while at hard limit
      assign hl_run[i] = q.st[i] == ST_ON && hard_s[i];
   end

   always_comb begin
      d = q;
      st_ld = '0;
      ov_ld = '0;
      hl_ld = '0;
      d.sync1 = {power_good, at_hard_limit, over_threshold, inrush_limiting};
      d.sync2 = q.sync1;
      d.tick = 1'b0;
      d.up_tick = 1'b0;
      if (q.div == 17'(TICK_CYCLES - 1)) begin
         d.div = '0;
         d.tick = 1'b1;
         d.up_div = 2'(q.up_div + 2'h1);
         d.up_tick = q.up_div == `POC_UP_DIV_MAX;
      end else begin
         d.div = 17'(q.div + 17'h1);
      end
      // ahb data phase write
      d.wr_pend = 1'b0;
      if (q.wr_pend) begin
         unique case (q.wr_addr)
            `POC_A_PWR_EN:   d.pwr_en = hwdata[3:0];
            `POC_A_OVLD_CFG: d.ovld_cfg = hwdata[11:0];
            `POC_A_TIMING:   d.tcfg = hwdata[3:0];
            `POC_A_HIGH_PWR: d.high_pwr = hwdata[3:0];
            `POC_A_MASK:     d.mask = hwdata[11:0];
            default: ;
         endcase
      end
      // ahb address phase, zero wait states
      d.ready = 1'b1;
      d.rdata = '0;
      if (addr_ph) begin
         d.wr_pend = hwrite;
         d.wr_addr = haddr[7:0];
         if (!hwrite) begin
            unique case (haddr[7:0])
               `POC_A_PWR_EN:   d.rdata = {28'h0, q.pwr_en};
               `POC_A_OVLD_CFG: d.rdata = {20'h0, q.ovld_cfg};
               `POC_A_TIMING:   d.rdata = {28'h0, q.tcfg};
               `POC_A_HIGH_PWR: d.rdata = {28'h0, q.high_pwr};
               `POC_A_EVENT: begin
                  d.rdata = {20'h0, q.evt};
                  // read clears, new events below still win
                  d.evt = '0;
               end
               `POC_A_MASK:     d.rdata = {20'h0, q.mask};
               `POC_A_STATUS:
                  d.rdata = {20'h0, good_s, q.inrush_lim, q.gate};
               default:         d.rdata = '0;
            endcase
         end
      end
      for (int i = 0; i < `POC_NPORT; i++) begin
         unique case (q.st[i])
            ST_OFF: begin
               if (q.pwr_en[i]) begin
                  st_ld[i] = 1'b1;
                  d.st[i] = ST_START;
               end
            end
            ST_START: begin
               if (!q.pwr_en[i]) begin
                  d.st[i] = ST_OFF;
               end else if (st_exp[i]) begin
                  if (inrush_s[i]) begin
                     d.st[i] = ST_OFF;
                     d.pwr_en[i] = 1'b0;
                     d.evt[`POC_EVT_INRUSH + i] = 1'b1;
                  end else begin
                     d.st[i] = ST_ON;
                     ov_ld[i] = 1'b1;
                     hl_ld[i] = 1'b1;
                  end
               end
            end
            ST_ON: begin
               if (!q.pwr_en[i]) begin
                  d.st[i] = ST_OFF;
               end else if (hl_exp[i]) begin
                  d.st[i] = ST_OFF;
                  d.pwr_en[i] = 1'b0;
                  d.evt[`POC_EVT_HARD + i] = 1'b1;
               end else if (ov_exp[i]) begin
                  d.st[i] = ST_OFF;
                  d.pwr_en[i] = 1'b0;
                  d.evt[`POC_EVT_OVLD + i] = 1'b1;
               end
            end
            default: d.st[i] = ST_OFF;
         endcase
         d.gate[i] = d.st[i] != ST_OFF;
         d.inrush_lim[i] = d.st[i] == ST_START;
         // hard limit with foldback once powered
         d.hard_en[i] = d.st[i] == ST_ON;
         d.fold2x[i] = d.st[i] == ST_ON && good_s[i] && q.high_pwr[i];
      end
      d.hard_hi = q.high_pwr;
      // overload threshold codes to sense stage
      d.thr = q.ovld_cfg;
      d.irq = |(d.evt & d.mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.ovld_cfg <= `POC_RST_OVLD_CFG;
         q.tcfg <= `POC_RST_TIMING;
         q.thr <= `POC_RST_OVLD_CFG;
      end else begin
         q <= d;
      end
   end

   assign hrdata             = q.rdata;
   assign hreadyout          = q.ready;
   assign hresp              = 1'b0;
   assign port_gate_en       = q.gate;
   assign inrush_limit_en    = q.inrush_lim;
   assign hard_limit_en      = q.hard_en;
   assign hard_limit_high    = q.hard_hi;
   assign foldback_2x        = q.fold2x;
   assign overload_threshold = q.thr;
   assign irq                = q.irq;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_win_end(int i);
      q.st[i] == ST_START && q.pwr_en[i] && st_exp[i];
   endsequence

   sequence s_cfg_write;
      addr_ph && hwrite && haddr[7:0] == `POC_A_OVLD_CFG ##1 1'b1;
   endsequence

   for (genvar i = 0; i < `POC_NPORT; i++) begin : g_chk
      a_start_window: assert property (
         q.st[i] == ST_OFF && q.pwr_en[i]
         |=> q.st[i] == ST_START ##1 inrush_limit_en[i] && port_gate_en[i])
         else $error("start window not entered");
      a_inrush_hold: assert property (
         q.st[i] == ST_START |-> inrush_limit_en[i] && !hard_limit_en[i])
         else $error("inrush limit not applied");
      a_inrush_fault: assert property (
         s_win_end(i) ##0 inrush_s[i]
         |=> !port_gate_en[i] && q.evt[`POC_EVT_INRUSH + i] && !q.pwr_en[i])
         else $error("inrush fault not taken");
      a_two_tiers: assert property (
         s_win_end(i) ##0 !inrush_s[i]
         |=> hard_limit_en[i] && !inrush_limit_en[i])
         else $error("tiers not armed");
      a_ovld_trip: assert property (
         q.st[i] == ST_ON && q.pwr_en[i] && ov_exp[i] && !hl_exp[i]
         |=> q.evt[`POC_EVT_OVLD + i] && !port_gate_en[i])
         else $error("overload trip missed");
      a_hard_trip: assert property (
         q.st[i] == ST_ON && q.pwr_en[i] && hl_exp[i]
         |=> q.evt[`POC_EVT_HARD + i] && !port_gate_en[i])
         else $error("hard limit trip missed");
      a_fold_curve: assert property (
         hard_limit_en[i] && $past(good_s[i]) && $past(q.high_pwr[i])
         |-> foldback_2x[i])
         else $error("foldback curve wrong");
   end

   a_thr_update: assert property (
      s_cfg_write ##1 1'b1 |=> overload_threshold == $past(hwdata[11:0], 2))
      else $error("threshold not forwarded");
   a_irq_mask: assert property (
      (q.evt & q.mask) != 12'h000 |-> irq)
      else $error("masked event without interrupt");
   a_flag_sticky: assert property (
      q.evt != 12'h000 && !addr_ph |=> (q.evt & $past(q.evt)) == $past(q.evt))
      else $error("event flag dropped");
   a_tick_period: assert property (
      q.tick |=> !q.tick)
      else $error("tick longer than a cycle");
endmodule // poc_top

// [poc_load_model.sv]
// behavioural powered load seen through the pass transistor and sense stage
module poc_load_model (
   input  wire logic       hclk,
   input  wire logic [3:0] port_gate_en,
   input  wire logic [3:0] inrush_limit_en,
   input  wire logic [3:0] hard_limit_en,
   input  wire logic [3:0] stuck_inrush,
   input  wire logic [3:0] overload,
   input  wire logic [3:0] short_ckt,
   output logic      [3:0] inrush_limiting,
   output logic      [3:0] over_threshold,
   output logic      [3:0] at_hard_limit,
   output logic      [3:0] power_good
);
   // an unpowered port has no current, so every sense line reads low
   always @(posedge hclk) begin
      inrush_limiting <= port_gate_en & inrush_limit_en & stuck_inrush;
      over_threshold  <= port_gate_en & hard_limit_en & overload;
      at_hard_limit   <= port_gate_en & hard_limit_en & short_ckt;
      power_good      <= port_gate_en & hard_limit_en;
   end
endmodule // poc_load_model

// [poc_top_tb.sv]
// register-level testbench of the port overcurrent protection block
`include "poc_defines.svh"
module poc_top_tb
   import poc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, irq;
   logic [3:0]  inl, ovt, ahl, pgd, gate, inr_en, hl_en, hl_hi, fb2;
   logic [3:0]  stuck = 4'h0, ovl = 4'h0, shrt = 4'h0;
   logic [11:0] thr;
   int          n_mismatch = 0, checks_done = 0, cyc = 0, n;
   always #5 hclk = ~hclk;
   poc_top #(.TICK_CYCLES(4)) i_poc_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .inrush_limiting(inl), .over_threshold(ovt),
      .at_hard_limit(ahl), .power_good(pgd), .port_gate_en(gate),
      .inrush_limit_en(inr_en), .hard_limit_en(hl_en),
      .hard_limit_high(hl_hi), .foldback_2x(fb2),
      .overload_threshold(thr), .irq(irq));
   poc_load_model i_poc_load_model (
      .hclk(hclk), .port_gate_en(gate), .inrush_limit_en(inr_en),
      .hard_limit_en(hl_en), .stuck_inrush(stuck), .overload(ovl),
      .short_ckt(shrt), .inrush_limiting(inl), .over_threshold(ovt),
      .at_hard_limit(ahl), .power_good(pgd));
   task automatic complete_run;
      if (n_mismatch == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one single AHB transfer, entered just after a rising edge
   task automatic ahb(logic w, logic [7:0] a, logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic rchk(string name, logic [7:0] a, logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(name, exp, rd);
   endtask
   task automatic cyc_n(int k);
      repeat (k) @(posedge hclk);
   endtask
   // count cycles until the given port loses its gate drive
   task automatic time_off(int p);
      n = 0;
      while (gate[p] !== 1'b0 && n < 200) begin
         @(posedge hclk);
         n++;
      end
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      cyc_n(10);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk("thr_rst", `POC_A_OVLD_CFG, 32'h333);
      rchk("tim_rst", `POC_A_TIMING, 32'h0);
      rchk("evt_rst", `POC_A_EVENT, 32'h0);
      rchk("unmapped", 8'h1c, 32'h0);
      ahb(1'b1, `POC_A_OVLD_CFG, 32'hfac);
      ahb(1'b1, `POC_A_HIGH_PWR, 32'h5);
      ahb(1'b1, `POC_A_TIMING, 32'he);
      ahb(1'b1, 8'h1c, 32'hfff);
      rchk("unmapped_wr", 8'h1c, 32'h0);
      chk("thr_out", 32'hfac, {20'h0, thr});
      chk("hl_high", 32'h5, {28'h0, hl_hi});
      ahb(1'b1, `POC_A_MASK, 32'h1);
      stuck <= 4'h1;
      ahb(1'b1, `POC_A_PWR_EN, 32'h7);
      cyc_n(4);
      chk("gate_start", 32'h7, {28'h0, gate});
      chk("inrush_en", 32'h7, {28'h0, inr_en});
      chk("hl_en_start", 32'h0, {28'h0, hl_en});
      cyc_n(260);
      chk("gate_win", 32'h6, {28'h0, gate});
      chk("inrush_end", 32'h0, {28'h0, inr_en});
      chk("hl_en_on", 32'h6, {28'h0, hl_en});
      chk("fold_2x", 32'h4, {28'h0, fb2});
      chk("irq_set", 32'h1, {31'h0, irq});
      rchk("evt_inrush", `POC_A_EVENT, 32'h1);
      cyc_n(2);
      chk("irq_clr", 32'h0, {31'h0, irq});
      rchk("evt_clr", `POC_A_EVENT, 32'h0);
      rchk("pwr_hwclr", `POC_A_PWR_EN, 32'h6);
      // overload code 2 is 15 ticks of 4 cycles, plus sync and tick phase
      ovl <= 4'h2;
      time_off(1);
      chk("ovld_time", 32'h1, {31'h0, n >= 56 && n <= 72});
      ovl <= 4'h0;
      rchk("evt_ovld", `POC_A_EVENT, 32'h20);
      chk("irq_masked", 32'h0, {31'h0, irq});
      // hard code 3 is 10 ticks
      shrt <= 4'h4;
      time_off(2);
      chk("hard_time", 32'h1, {31'h0, n >= 36 && n <= 52});
      shrt <= 4'h0;
      rchk("evt_hard", `POC_A_EVENT, 32'h400);
      // two 10-tick overloads split by a long quiet time must not trip
      ahb(1'b1, `POC_A_MASK, 32'hfff);
      ahb(1'b1, `POC_A_PWR_EN, 32'h2);
      cyc_n(260);
      ovl <= 4'h2;
      cyc_n(40);
      ovl <= 4'h0;
      cyc_n(200);
      ovl <= 4'h2;
      cyc_n(40);
      ovl <= 4'h0;
      cyc_n(4);
      chk("count_up", 32'h2, {28'h0, gate});
      chk("irq_none", 32'h0, {31'h0, irq});
      rchk("evt_none", `POC_A_EVENT, 32'h0);
      complete_run();
   end
endmodule // poc_top_tb
